// *** hw/chip_reg_file.v ***
`timescale 1ns/1ps
`include "ring_adapter_defines.vh"

// Small memory: four ring chips by four chip registers, registered read
module chip_reg_file
#(
	parameter W = 16
)
(
	// Clock and reset
	input  wire         i_clk,
	input  wire         i_rst,
	// Write port
	input  wire         i_we,
	input  wire [3:0]   i_waddr,
	input  wire [W-1:0] i_wdata,
	// Read port
	input  wire [3:0]   i_raddr,
	output reg  [W-1:0] o_rdata
);
	reg [W-1:0] mem_q [0:15];
	integer k;

	always @(posedge i_clk)
	begin
		if (i_rst)
		begin
			for (k = 0; k < 16; k = k + 1)
				mem_q[k] <= {W{1'b0}};
			o_rdata <= {W{1'b0}};
		end
		else
		begin
			if (i_we)
				mem_q[i_waddr] <= i_wdata;
			o_rdata <= mem_q[i_raddr];
		end
	end
endmodule // chip_reg_file

// *** hw/mmio_wrap_sim.v ***
`timescale 1ns/1ps
`include "ring_adapter_defines.vh"

// Simulated ring chip answer in wrap mode: fixed latency, no timeout
module mmio_wrap_sim
(
	// Clock and reset
	input  wire       i_clk,
	input  wire       i_rst,
	// Request
	input  wire       i_start,
	// Completion
	output reg        o_done
);
	reg [1:0] cnt_q;
	reg       busy_q;

	always @(posedge i_clk)
	begin
		if (i_rst)
		begin
			cnt_q  <= `ZERO2;
			busy_q <= 1'b0;
			o_done <= 1'b0;
		end
		else
		begin
			o_done <= 1'b0;
			if (i_start && !busy_q)
			begin
				busy_q <= 1'b1;
				cnt_q  <= `MMIO_LAT;
			end
			else if (busy_q)
			begin
				if (cnt_q == `ZERO2)
				begin
					busy_q <= 1'b0;
					o_done <= 1'b1;
				end
				else
					cnt_q <= cnt_q - 2'h1;
			end
		end
	end
endmodule // mmio_wrap_sim

// *** hw/ring_adapter_defines.vh ***
`ifndef RING_ADAPTER_DEFINES_VH
`define RING_ADAPTER_DEFINES_VH

// ----------------------------------------
// Command opcodes (8-bit)
// ----------------------------------------
`define OP_SET_CTRL      8'h01
`define OP_GET_CTRL      8'h02
`define OP_SET_CHIPCTL   8'h03
`define OP_GET_CHIPCTL   8'h04
`define OP_WR_BUF        8'h05
`define OP_RD_BUF        8'h06
`define OP_WR_XBUF       8'h07
`define OP_RD_XBUF       8'h08
`define OP_WR_IRBR       8'h09
`define OP_RD_IRBR       8'h0A
`define OP_LD_LID        8'h0B
`define OP_RD_LID        8'h0C
`define OP_WR_DIAG       8'h0D
`define OP_RD_DIAG       8'h0E
`define OP_PRESET        8'h0F
`define OP_GET_L1        8'h10
`define OP_GET_MAINT     8'h11
`define OP_RD_STEAL      8'h12
`define OP_GET_L2        8'h14
`define OP_MMIO_WR       8'h20
`define OP_MMIO_RD       8'h30
// ----------------------------------------
// Opcode field layout
// ----------------------------------------
`define OP_L2_MASK       8'hFC
`define OP_MMIO_MASK     8'hF0
`define OP_CHIP_HI       3
`define OP_CHIP_LO       2
`define OP_REG_HI        1
`define OP_REG_LO        0
// ----------------------------------------
// Diagnostic register bits
// ----------------------------------------
`define DG_START         0
`define DG_WRAP          1
`define DG_PIODMA        2
`define DG_ADR_B0        3
`define DG_ADR_B1        4
`define DG_DAT_B0        5
`define DG_DAT_B1        6
`define DG_INT_B0        7
`define DG_INT_B1        8
// ----------------------------------------
// First-level status bits
// ----------------------------------------
`define L1_INVALID       0
`define L1_IOCHECK       1
`define L1_RDPAR         2
`define L1_WRPAR         3
// ----------------------------------------
// Reset values and misc
// ----------------------------------------
`define ZERO16           16'h0000
`define ZERO2            2'h0
`define ZERO4            4'h0
`define CTRL_RST_BIT     1
`define STEAL_DEFAULT    16'h0000
`define MMIO_LAT         2'h2

`endif

// *** hw/ring_adapter_pio_register_diag.v ***
`timescale 1ns/1ps
`include "ring_adapter_defines.vh"

module ring_adapter_pio_register_diag
#(
	parameter W = 16
)
(
	// Clock and reset
	input  wire         i_clk,
	input  wire         i_rst,
	// Channel command
	input  wire         i_cmd_valid,
	input  wire [7:0]   i_cmd_op,
	input  wire [1:0]   i_cmd_op_par,
	input  wire [W-1:0] i_cmd_wdata,
	input  wire [1:0]   i_cmd_wpar,
	// Steal control word sent on central-unit address error
	input  wire         i_steal_cap,
	input  wire [W-1:0] i_steal_word,
	// Channel answer
	output reg          o_ack,
	output reg  [W-1:0] o_rdata,
	output reg  [1:0]   o_rpar,
	// Block state
	output reg  [1:0]   o_ctrl,
	output reg  [W-1:0] o_chip_ctrl,
	output reg          o_irq_launch,
	output reg          o_dma_launch
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	localparam S_IDLE = 2'b01;
	localparam S_MMIO = 2'b10;

	reg [1:0]   state_q;
	reg [1:0]   ctrl_q;
	reg         rst_latch_q;
	reg [W-1:0] chipctl_q;
	reg [W-1:0] buf_q;
	reg [1:0]   buf_pbad_q;
	reg [W-1:0] xbuf_q;
	reg [1:0]   xbuf_pbad_q;
	reg [W-1:0] irbr_q;
	reg [W-1:0] lid_q;
	reg [1:0]   lid_pbad_q;
	reg [W-1:0] diag_q;
	reg [3:0]   l1_q;
	reg [W-1:0] maint_q;
	reg [W-1:0] steal_q;
	reg [3:0]   mm_addr_q;
	reg         mm_rd_q;
	reg [W-1:0] l2_q [0:3];

	wire [W-1:0] mem_rdata;
	wire         mm_done;
	wire         mm_go = (state_q == S_MMIO);

	// Parity per byte, odd
	wire        par_ok_a = (^{i_cmd_op, i_cmd_op_par[0]}) && (i_cmd_op_par[0] == i_cmd_op_par[1]);
	wire        par_ok_d0 = ^{i_cmd_wdata[7:0], i_cmd_wpar[0]};
	wire        par_ok_d1 = ^{i_cmd_wdata[15:8], i_cmd_wpar[1]};
	wire        start  = diag_q[`DG_START];
	wire        wrap   = diag_q[`DG_WRAP];
	wire [1:0]  f_adr  = start ? {diag_q[`DG_ADR_B1], diag_q[`DG_ADR_B0]} : `ZERO2;
	wire [1:0]  f_dat  = start ? {diag_q[`DG_DAT_B1], diag_q[`DG_DAT_B0]} : `ZERO2;
	wire [1:0]  f_int  = start ? {diag_q[`DG_INT_B1], diag_q[`DG_INT_B0]} : `ZERO2;
	wire        is_mm  = ((i_cmd_op & `OP_MMIO_MASK) == `OP_MMIO_WR) ||
	                     ((i_cmd_op & `OP_MMIO_MASK) == `OP_MMIO_RD);
	wire        is_l2  = ((i_cmd_op & `OP_L2_MASK) == `OP_GET_L2);
	wire [3:0]  chipreg = {i_cmd_op[`OP_CHIP_HI:`OP_CHIP_LO],
	                       i_cmd_op[`OP_REG_HI:`OP_REG_LO]};

	reg         valid_op;
	reg         is_write;
	reg [W-1:0] rd_val;
	reg [1:0]   rd_pbad;

	// ----------------------------------------
	// Opcode decode and read mux
	// ----------------------------------------
	always @*
	begin
		valid_op = 1'b1;
		is_write = 1'b0;
		rd_val   = `ZERO16;
		rd_pbad  = `ZERO2;
		case (i_cmd_op)
			`OP_SET_CTRL:    is_write = 1'b1;
			`OP_GET_CTRL:    rd_val = {{(W-3){1'b0}}, rst_latch_q, ctrl_q};
			`OP_SET_CHIPCTL: is_write = 1'b1;
			`OP_GET_CHIPCTL: rd_val = chipctl_q;
			`OP_WR_BUF:      is_write = 1'b1;
			`OP_RD_BUF:
			begin
				rd_val  = buf_q;
				rd_pbad = buf_pbad_q;
			end
			`OP_WR_XBUF:     is_write = 1'b1;
			`OP_RD_XBUF:
			begin
				rd_val  = xbuf_q;
				rd_pbad = xbuf_pbad_q;
			end
			`OP_WR_IRBR:     is_write = 1'b1;
			`OP_RD_IRBR:     rd_val = irbr_q;
			`OP_LD_LID:      is_write = 1'b1;
			`OP_RD_LID:
			begin
				rd_val  = lid_q;
				rd_pbad = lid_pbad_q;
			end
			`OP_WR_DIAG:     is_write = 1'b1;
			`OP_RD_DIAG:     rd_val = diag_q;
			`OP_PRESET:      is_write = 1'b1;
			`OP_GET_L1:      rd_val = {{(W-4){1'b0}}, l1_q};
			`OP_GET_MAINT:   rd_val = maint_q;
			`OP_RD_STEAL:    rd_val = steal_q;
			default:
			begin
				if (is_l2)
					rd_val = l2_q[i_cmd_op[1:0]];
				else if (is_mm)
					is_write = ((i_cmd_op & `OP_MMIO_MASK) == `OP_MMIO_WR);
				else
					valid_op = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Command execution
	// ----------------------------------------
	integer j;
	always @(posedge i_clk)
	begin
		if (i_rst)
		begin
			state_q     <= S_IDLE;
			ctrl_q      <= `ZERO2;
			rst_latch_q <= 1'b0;
			chipctl_q   <= `ZERO16;
			buf_q       <= `ZERO16;
			buf_pbad_q  <= `ZERO2;
			xbuf_q      <= `ZERO16;
			xbuf_pbad_q <= `ZERO2;
			irbr_q      <= `ZERO16;
			lid_q       <= `ZERO16;
			lid_pbad_q  <= `ZERO2;
			diag_q      <= `ZERO16;
			l1_q        <= `ZERO4;
			maint_q     <= `ZERO16;
			steal_q     <= `STEAL_DEFAULT;
			mm_addr_q   <= `ZERO4;
			mm_rd_q     <= 1'b0;
			for (j = 0; j < 4; j = j + 1)
				l2_q[j] <= `ZERO16;
			o_ack        <= 1'b0;
			o_rdata      <= `ZERO16;
			o_rpar       <= `ZERO2;
			o_ctrl       <= `ZERO2;
			o_chip_ctrl  <= `ZERO16;
			o_irq_launch <= 1'b0;
			o_dma_launch <= 1'b0;
		end
		else
		begin
			o_ack        <= 1'b0;
			o_irq_launch <= 1'b0;
			o_dma_launch <= 1'b0;
			o_ctrl       <= ctrl_q;
			o_chip_ctrl  <= chipctl_q;
			if (i_steal_cap)
				steal_q <= i_steal_word;
			// Outside wrap, irq/busreq bits launch directly
			if (!wrap && irbr_q != `ZERO16)
			begin
				o_irq_launch <= |irbr_q[7:0];
				o_dma_launch <= |irbr_q[15:8];
			end
			case (state_q)
				S_IDLE:
				begin
					if (i_cmd_valid)
					begin
						if (!par_ok_a || f_adr != `ZERO2)
						begin
							// Silent: channel times out
							l1_q[`L1_IOCHECK] <= 1'b1;
							if (f_adr != `ZERO2)
								diag_q[`DG_START] <= 1'b0;
						end
						else if (!valid_op)
							l1_q[`L1_INVALID] <= 1'b1;
						else if (is_write && f_dat != `ZERO2)
						begin
							// Drop the write, no answer
							l1_q[`L1_WRPAR]   <= 1'b1;
							diag_q[`DG_START] <= 1'b0;
						end
						else if (is_write && !(par_ok_d0 && par_ok_d1))
							l1_q[`L1_WRPAR] <= 1'b1;
						else
						begin
							o_ack   <= !is_mm;
							o_rdata <= rd_val;
							// Stored bad parity flips the returned bit
							o_rpar  <= {~^rd_val[15:8], ~^rd_val[7:0]} ^ rd_pbad;
							if (!is_write)
							begin
								if (f_dat != `ZERO2)
								begin
									o_rpar <= {~^rd_val[15:8], ~^rd_val[7:0]} ^ f_dat;
									l1_q[`L1_RDPAR]   <= 1'b1;
									diag_q[`DG_START] <= 1'b0;
								end
								else if (rd_pbad != `ZERO2)
									l1_q[`L1_RDPAR] <= 1'b1;
								if (i_cmd_op == `OP_GET_CTRL)
									rst_latch_q <= 1'b0;
								if (i_cmd_op == `OP_GET_L1)
									l1_q <= `ZERO4;
								if (is_l2)
									l2_q[i_cmd_op[1:0]] <= `ZERO16;
							end
							case (i_cmd_op)
								`OP_SET_CTRL:    ctrl_q <= i_cmd_wdata[1:0];
								`OP_SET_CHIPCTL: chipctl_q <= i_cmd_wdata;
								`OP_WR_BUF:
								begin
									buf_q      <= i_cmd_wdata;
									buf_pbad_q <= f_int;
								end
								`OP_WR_XBUF:
								begin
									xbuf_q      <= i_cmd_wdata;
									xbuf_pbad_q <= f_int;
								end
								`OP_WR_IRBR:     irbr_q <= i_cmd_wdata;
								`OP_LD_LID:
								begin
									lid_q      <= i_cmd_wdata;
									lid_pbad_q <= f_int;
								end
								`OP_WR_DIAG:     diag_q <= i_cmd_wdata;
								`OP_PRESET:
								begin
									diag_q      <= `ZERO16;
									irbr_q      <= `ZERO16;
									buf_q       <= `ZERO16;
									buf_pbad_q  <= `ZERO2;
									xbuf_q      <= `ZERO16;
									xbuf_pbad_q <= `ZERO2;
									lid_q       <= `ZERO16;
									lid_pbad_q  <= `ZERO2;
									maint_q     <= `ZERO16;
									for (j = 0; j < 4; j = j + 1)
										l2_q[j] <= `ZERO16;
									rst_latch_q <= 1'b1;
								end
								default:
								begin
									if (is_mm)
									begin
										mm_addr_q <= chipreg;
										mm_rd_q   <= !is_write;
										if (is_write)
											buf_q <= i_cmd_wdata;
										state_q <= S_MMIO;
									end
								end
							endcase
							if (f_int != `ZERO2 && (i_cmd_op == `OP_WR_BUF ||
							    i_cmd_op == `OP_WR_XBUF || i_cmd_op == `OP_LD_LID))
								diag_q[`DG_START] <= 1'b0;
						end
					end
					// Wrap mode: stored irq/busreq bits act only on start
					if (wrap && start && irbr_q != `ZERO16 && !i_cmd_valid)
					begin
						o_irq_launch      <= |irbr_q[7:0];
						o_dma_launch      <= |irbr_q[15:8];
						diag_q[`DG_START] <= 1'b0;
					end
				end
				S_MMIO:
				begin
					if (mm_done)
					begin
						o_ack   <= 1'b1;
						// Wrap read data comes from the buffer
						o_rdata <= wrap ? buf_q : mem_rdata;
						o_rpar  <= wrap ? {~^buf_q[15:8], ~^buf_q[7:0]}
						                : {~^mem_rdata[15:8], ~^mem_rdata[7:0]};
						state_q <= S_IDLE;
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Chip register store and wrap timing
	// ----------------------------------------
	chip_reg_file #(.W(W)) u_regs
	(
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_we    (mm_go && !mm_rd_q && mm_done),
		.i_waddr (mm_addr_q),
		.i_wdata (buf_q),
		.i_raddr (mm_addr_q),
		.o_rdata (mem_rdata)
	);

	mmio_wrap_sim u_wrap
	(
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		// No restart on the completion cycle, else a stale done hits the next access
		.i_start (mm_go && !mm_done),
		.o_done  (mm_done)
	);
endmodule // ring_adapter_pio_register_diag

// *** test/ring_adapter_pio_register_diag_sva.sv ***
`timescale 1ns/1ps
`include "ring_adapter_defines.vh"

module ring_adapter_chk
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Channel command
	input  wire logic        i_cmd_valid,
	input  wire logic [7:0]  i_cmd_op,
	input  wire logic [1:0]  i_cmd_op_par,
	input  wire logic [15:0] i_cmd_wdata,
	// Answer and state
	input  wire logic        o_ack,
	input  wire logic [1:0]  o_ctrl,
	input  wire logic [15:0] o_chip_ctrl,
	input  wire logic        o_irq_launch,
	input  wire logic        o_dma_launch
);
	wire op_ok = i_cmd_op_par == {2{~^i_cmd_op}};
	wire mmio  = i_cmd_op[7:5] == 3'h1;
	wire known = (i_cmd_op >= 8'h01 && i_cmd_op <= 8'h12)
		|| (i_cmd_op >= 8'h14 && i_cmd_op <= 8'h17) || mmio;

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);

	a_ack_cause:
	assert property (o_ack |-> $past(i_cmd_valid) || $past(i_cmd_valid, 6))
		else $error("answer without a command");
	a_par_refuse:
	assert property (i_cmd_valid && !op_ok |=> !o_ack)
		else $error("bad opcode parity answered");
	a_op_refuse:
	assert property (i_cmd_valid && !known |=> !o_ack)
		else $error("unassigned opcode answered");
	a_ctrl_set:
	assert property (o_ack && $past(i_cmd_valid && i_cmd_op == `OP_SET_CTRL)
		|=> o_ctrl == $past(i_cmd_wdata[1:0], 2)) else $error("control value wrong");
	a_chip_set:
	assert property (o_ack && $past(i_cmd_valid && i_cmd_op == `OP_SET_CHIPCTL)
		|=> o_chip_ctrl == $past(i_cmd_wdata, 2)) else $error("chip control wrong");
	a_launch_cause:
	assert property ($rose(o_irq_launch) || $rose(o_dma_launch)
		|-> $past(i_cmd_op) == `OP_WR_DIAG || $past(i_cmd_op, 2) == `OP_WR_DIAG)
		else $error("launch not caused by start");
	a_mmio_lat:
	assert property (i_cmd_valid && op_ok && mmio && !$past(i_cmd_valid)
		&& !$past(i_cmd_valid, 3) |=> !o_ack [*5] ##1 o_ack)
		else $error("memory-mapped answer late");
	a_reset_idle:
	assert property ($fell(i_rst) |-> !o_ack && o_ctrl == 2'h0 && !o_irq_launch
		&& !o_dma_launch) else $error("outputs not idle after reset");
endmodule // ring_adapter_chk

bind ring_adapter_pio_register_diag ring_adapter_chk u_chk (.i_clk(i_clk), .i_rst(i_rst),
	.i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op), .i_cmd_op_par(i_cmd_op_par),
	.i_cmd_wdata(i_cmd_wdata), .o_ack(o_ack), .o_ctrl(o_ctrl), .o_chip_ctrl(o_chip_ctrl),
	.o_irq_launch(o_irq_launch), .o_dma_launch(o_dma_launch));

// *** test/ring_adapter_pio_register_diag_test.sv ***
`timescale 1ns/1ps
`include "ring_adapter_defines.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end

module ring_adapter_pio_register_diag_test;
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        i_steal_cap = 1'b0;
	logic [15:0] i_steal_word = 16'h0000;
	wire         v, o_ack, o_irq_launch, o_dma_launch;
	wire  [7:0]  op;
	wire  [1:0]  opp, wp, o_rpar, o_ctrl;
	wire  [15:0] wd, o_rdata, o_chip_ctrl;
	int          miscompares = 0, n_checks = 0, cyc = 0, k, n_launch = 0, base;
	logic        g;
	logic [15:0] r;
	logic [1:0]  p;
	logic [15:0] pat[2] = '{16'hA55A, 16'h5AA5};
	logic [7:0]  wo[7] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h09, 8'h0B, 8'h0D};
	logic [15:0] msk[7] = '{16'h0003, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h01FE};
	logic [7:0]  zro[10] = '{8'h0E, 8'h0A, 8'h06, 8'h08, 8'h0C, 8'h14, 8'h15, 8'h16, 8'h17, 8'h11};
	logic [7:0]  bad_op[3] = '{8'h13, 8'h18, 8'h40};

	always #5 i_clk = ~i_clk;

	// Hang guard, far above the expected run length
	always @(posedge i_clk)
	begin
		cyc++;
		if (o_irq_launch)
			n_launch++;
		if (o_dma_launch)
			n_launch++;
		if (cyc == 20000)
		begin
			miscompares++;
			end_of_test();
		end
	end

	ring_host_model host (.i_clk(i_clk), .i_ack(o_ack), .i_rdata(o_rdata), .i_rpar(o_rpar),
		.o_valid(v), .o_op(op), .o_op_par(opp), .o_wdata(wd), .o_wpar(wp));

	ring_adapter_pio_register_diag DUT (.i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(v),
		.i_cmd_op(op), .i_cmd_op_par(opp), .i_cmd_wdata(wd), .i_cmd_wpar(wp),
		.i_steal_cap(i_steal_cap), .i_steal_word(i_steal_word), .o_ack(o_ack),
		.o_rdata(o_rdata), .o_rpar(o_rpar), .o_ctrl(o_ctrl), .o_chip_ctrl(o_chip_ctrl),
		.o_irq_launch(o_irq_launch), .o_dma_launch(o_dma_launch));

	task automatic wr(input logic [7:0] o, input logic [15:0] d);
		host.cmd(o, d, 2'h0, g, r, p);
		`CHK(g, 1'b1)
	endtask

	task automatic rd(input logic [7:0] o, input logic [15:0] m, input logic [15:0] e);
		host.cmd(o, 16'h0000, 2'h0, g, r, p);
		`CHK({g, r & m}, {1'b1, e})
	endtask

	task automatic quiet(input logic [7:0] o, input logic [15:0] d, input logic [1:0] bad);
		host.cmd(o, d, bad, g, r, p);
		`CHK(g, 1'b0)
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		rd(`OP_GET_CTRL, 16'h0000, 16'h0000);
		rd(`OP_GET_L1, 16'h0000, 16'h0000);
		wr(`OP_WR_DIAG, 16'h0006);
		// Start bit kept clear so read-back forces nothing
		foreach (pat[j])
			foreach (wo[m])
			begin
				wr(wo[m], pat[j] & msk[m]);
				rd(wo[m] + 8'h01, msk[m], pat[j] & msk[m]);
			end
		$display("register read-back done");
		wr(`OP_PRESET, 16'h0000);
		rd(`OP_GET_CTRL, 16'h0004, 16'h0004);
		rd(`OP_GET_CTRL, 16'h0004, 16'h0000);
		foreach (zro[m])
			rd(zro[m], 16'hFFFF, 16'h0000);
		$display("programmed reset done");
		for (k = 1; k < 4; k++)
		begin
			quiet(`OP_RD_BUF, 16'h0000, k[1:0]);
			rd(`OP_GET_L1, 16'hFFFF, 16'h0002);
			wr(`OP_WR_DIAG, 16'h0001 | {11'h000, k[1:0], 3'h0});
			quiet(`OP_RD_BUF, 16'h0000, 2'h0);
			rd(`OP_GET_L1, 16'hFFFF, 16'h0002);
			rd(`OP_RD_DIAG, 16'h0001, 16'h0000);
			quiet(bad_op[k - 1], 16'h0000, 2'h0);
			rd(`OP_GET_L1, 16'hFFFF, 16'h0001);
		end
		$display("refused commands done");
		wr(`OP_WR_BUF, 16'h1234);
		for (k = 1; k < 4; k++)
		begin
			wr(`OP_WR_DIAG, 16'h0001 | {9'h000, k[1:0], 5'h00});
			quiet(`OP_WR_BUF, 16'h5678, 2'h0);
			rd(`OP_GET_L1, 16'hFFFF, 16'h0008);
			rd(`OP_RD_DIAG, 16'h0001, 16'h0000);
			rd(`OP_RD_BUF, 16'hFFFF, 16'h1234);
			wr(`OP_WR_DIAG, 16'h0001 | {9'h000, k[1:0], 5'h00});
			rd(`OP_RD_BUF, 16'hFFFF, 16'h1234);
			`CHK(p, {~^8'h12, ~^8'h34} ^ k[1:0])
			rd(`OP_GET_L1, 16'hFFFF, 16'h0004);
		end
		// Bad parity stored with the data, seen on the later read
		wr(`OP_WR_DIAG, 16'h0181);
		wr(`OP_WR_BUF, 16'h1234);
		rd(`OP_RD_DIAG, 16'h0001, 16'h0000);
		rd(`OP_RD_BUF, 16'hFFFF, 16'h1234);
		`CHK(p, {~^8'h12, ~^8'h34} ^ 2'h3)
		rd(`OP_GET_L1, 16'hFFFF, 16'h0004);
		$display("forced data parity done");
		wr(`OP_WR_DIAG, 16'h0006);
		// Wrap mode: stored launch bits wait for the start bit
		base = n_launch;
		wr(`OP_WR_IRBR, 16'h0101);
		repeat (2) @(posedge i_clk);
		`CHK(n_launch, base)
		wr(`OP_WR_DIAG, 16'h0007);
		repeat (2) @(posedge i_clk);
		`CHK(n_launch, base + 2)
		wr(`OP_WR_IRBR, 16'h0000);
		for (k = 0; k < 16; k++)
		begin
			wr({4'h2, k[3:0]}, {12'h0F0, k[3:0]});
			rd({4'h3, ~k[3:0]}, 16'hFFFF, {12'h0F0, k[3:0]});
		end
		wr(`OP_WR_DIAG, 16'h0000);
		for (k = 0; k < 16; k++)
			wr({4'h2, k[3:0]}, {8'hB0, k[3:0], k[3:0]});
		for (k = 0; k < 16; k++)
			rd({4'h3, k[3:0]}, 16'hFFFF, {8'hB0, k[3:0], k[3:0]});
		$display("memory-mapped access done");
		@(posedge i_clk);
		i_steal_word <= 16'hC3A5;
		i_steal_cap <= 1'b1;
		@(posedge i_clk);
		i_steal_cap <= 1'b0;
		rd(`OP_RD_STEAL, 16'hFFFF, 16'hC3A5);
		$display("steal word done");
		end_of_test();
	end
endmodule // ring_adapter_pio_register_diag_test

// *** test/ring_host_model.sv ***
`timescale 1ns/1ps

module ring_host_model
(
	// Clock and answer
	input  wire logic        i_clk,
	input  wire logic        i_ack,
	input  wire logic [15:0] i_rdata,
	input  wire logic [1:0]  i_rpar,
	// Command
	output logic             o_valid = 1'b0,
	output logic [7:0]       o_op = 8'h00,
	output logic [1:0]       o_op_par = 2'h0,
	output logic [15:0]      o_wdata = 16'h0000,
	output logic [1:0]       o_wpar = 2'h0
);
	task automatic cmd(input logic [7:0] op, input logic [15:0] d, input logic [1:0] bad,
		output logic got, output logic [15:0] rd, output logic [1:0] rp);
		int i;
		got = 1'b0;
		rd = 16'h0000;
		rp = 2'h0;
		@(posedge i_clk);
		o_valid <= 1'b1;
		o_op <= op;
		o_op_par <= {2{~^op}} ^ bad;
		o_wdata <= d;
		o_wpar <= {~^d[15:8], ~^d[7:0]};
		// Silence for eight cycles is a failed command
		for (i = 0; i < 8 && !got; i++)
		begin
			@(posedge i_clk);
			if (i == 0)
			begin
				// Released lines must not keep the last value
				o_valid <= 1'b0;
				o_op <= ~op;
				o_wdata <= ~d;
			end
			if (i_ack)
			begin
				got = 1'b1;
				rd = i_rdata;
				rp = i_rpar;
			end
		end
	endtask
endmodule // ring_host_model
